// ===== design/adc_lfsr.sv
// Purpose: free running pseudo random source for the slot value
// Assumes: any nonzero seed
// Notes:   16-bit maximal length taps
module adc_lfsr #(
  parameter logic [15:0] SEED = 16'hACE1
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // random word
  output logic      [15:0] rnd
);

  logic next_bit;

  assign next_bit = rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rnd <= SEED;
    end else begin
      rnd <= {rnd[14:0], next_bit};
    end
  end

endmodule // adc_lfsr

// ===== design/adc_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous inputs
// Assumes: inputs are quasi-static relative to the clock
// Notes:   first stage feeds only the second
module adc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // adc_sync

// ===== design/adc_top.sv
// Purpose: antenna driver control registers and pin logic
// Assumes: carrier, external envelope and field detector are asynchronous pins
// Notes:   analog depth control is an output level, not modelled here
// Function
// - enabled driver output inverts when its invert-when-on bit is set
// - disabled driver output inverts when its invert-when-off bit is set
// - continuous-wave bit makes driver b send unmodulated carrier
// - without continuous-wave, driver b is modulated like driver a
// - field check with enable write refuses setting enables while field present
// - enable bit makes the pin send carrier modulated by data
// - driver control register resets to 0x80
// - auto-off clears active drivers after the last transmitted bit
// - force-full-ask demands 100 percent modulation ignoring depth setting
// - field-wake restarts from soft power-down on level detector trigger
// - automation bit 4 is reserved, has no function, reads 0
// - collision avoidance picks internal random slot value n
// - initial avoidance runs then clears itself when field switched on
// - driver b auto-enables after field off plus delay, or initial delay
// - driver a auto-enables under the same conditions
// - automation register resets to 0x00
// - source select picks tristate, coder, external envelope or high
`include "adc_defines.svh"

module adc_top
  import adc_pkg::*;
#(
  parameter int ADT_CYC  = `ADC_ADT_CYC,
  parameter int IDT_CYC  = `ADC_IDT_CYC,
  parameter int SLOT_CYC = `ADC_SLOT_CYC,
  parameter int CNT_W    = 16
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // transmit side, same clock
  input  wire logic       coder_envelope,
  input  wire logic       tx_last_bit_done,
  input  wire logic       soft_power_down,
  // asynchronous inputs
  input  wire logic       carrier_in,
  input  wire logic       external_envelope_input,
  input  wire logic       field_detected,
  input  wire logic       rf_level_trigger,
  // antenna pins
  output logic            antenna_pin_a_o,
  output logic            antenna_pin_a_oe,
  output logic            antenna_pin_b_o,
  output logic            antenna_pin_b_oe,
  // status towards the core
  output logic            full_depth_request,
  output logic            wake_request,
  output logic      [1:0] slot_n
);

  adc_bus_t   bus;
  logic [7:0] ctrl;
  logic [7:0] automation;
  logic [1:0] src_sel;
  adc_src_t   src;
  logic [3:0] async_raw;
  logic [3:0] async_sync;
  logic       carrier;
  logic       ext_env;
  logic       field;
  logic       level_trig;
  logic       level_trig_d;
  logic [15:0] rnd;
  adc_state_t state;
  adc_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] delay_target;
  logic       auto_fire;
  logic       wr_ctrl;
  logic       wr_auto;
  logic       wr_src;
  logic       refuse;
  logic [1:0] next_en;
  logic       envelope;
  adc_pin_t   pin_a;
  adc_pin_t   pin_b;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // input synchronisation
  assign async_raw = {carrier_in, external_envelope_input, field_detected, rf_level_trigger};

  adc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock   (clock),
    .arst_n  (arst_n),
    .async_in(async_raw),
    .sync_out(async_sync)
  );

  assign carrier    = async_sync[3];
  assign ext_env    = async_sync[2];
  assign field      = async_sync[1];
  assign level_trig = async_sync[0];

  adc_lfsr u_lfsr (
    .clock (clock),
    .arst_n(arst_n),
    .rnd   (rnd)
  );

  // address decode
  function automatic logic hit(input adc_bus_t b, input logic [7:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  assign wr_ctrl = hit(bus, `ADC_OFS_CTRL);
  assign wr_auto = hit(bus, `ADC_OFS_AUTO);
  assign wr_src  = hit(bus, `ADC_OFS_SRC);

  // field check only qualifies the write that carries it
  assign refuse = bus.wdata[`ADC_FIELD_CHECK] && field;

  always_comb begin
    next_en = ctrl[`ADC_EN_B:`ADC_EN_A];
    if (tx_last_bit_done && automation[`ADC_AUTO_OFF]) begin
      next_en = 2'h0;
    end
    if (auto_fire) begin
      next_en = next_en | {automation[`ADC_AUTO_EN_B], automation[`ADC_AUTO_EN_A]};
    end
    if (wr_ctrl) begin
      if (refuse) begin
        // cannot set, clearing still allowed
        next_en = ctrl[`ADC_EN_B:`ADC_EN_A] & bus.wdata[`ADC_EN_B:`ADC_EN_A];
      end else begin
        next_en = bus.wdata[`ADC_EN_B:`ADC_EN_A];
      end
    end
  end

  // driver control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `ADC_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl[7:`ADC_CW_B] <= bus.wdata[7:`ADC_CW_B];
      end
      ctrl[`ADC_FIELD_CHECK] <= 1'b0;
      ctrl[`ADC_EN_B:`ADC_EN_A] <= next_en;
    end
  end

  // automation register; software write wins over self-clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      automation <= `ADC_RST_AUTO;
    end else begin
      if (wr_auto) begin
        automation <= bus.wdata;
        automation[`ADC_AUTO_RSVD] <= 1'b0;
      end else if (auto_fire && automation[`ADC_INIT_AVOID]) begin
        automation[`ADC_INIT_AVOID] <= 1'b0;
      end
    end
  end

  // source select register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      src_sel <= 2'(`ADC_RST_SRC >> `ADC_SRC_LSB);
    end else if (wr_src) begin
      src_sel <= bus.wdata[`ADC_SRC_MSB:`ADC_SRC_LSB];
    end
  end

  assign src = adc_src_t'(src_sel);

  // read port, data one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `ADC_OFS_CTRL: reg_rdata <= ctrl & 8'hFB;
        `ADC_OFS_AUTO: reg_rdata <= automation & 8'hEF;
        `ADC_OFS_SRC:  reg_rdata <= {2'h0, src_sel, 4'h0};
        default:       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // collision avoidance slot value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slot_n <= 2'h0;
    end else if (automation[`ADC_CA_ON] && state == ADC_ST_IDLE) begin
      slot_n <= rnd[1:0];
    end else if (!automation[`ADC_CA_ON]) begin
      slot_n <= 2'h0;
    end
  end

  // random slots stretch the wait only with avoidance on
  always_comb begin
    delay_target = CNT_W'(ADT_CYC) + CNT_W'(SLOT_CYC) * CNT_W'(slot_n);
    if (state == ADC_ST_INIT) begin
      delay_target = CNT_W'(IDT_CYC) + CNT_W'(SLOT_CYC) * CNT_W'(slot_n);
    end
  end

  // automatic switch-on sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ADC_ST_IDLE: begin
        if (automation[`ADC_AUTO_EN_B:`ADC_AUTO_EN_A] != 2'h0) begin
          if (automation[`ADC_INIT_AVOID]) begin
            next_state = ADC_ST_INIT;
          end else if (field) begin
            next_state = ADC_ST_FIELD;
          end
        end
      end
      ADC_ST_FIELD: begin
        if (!field) begin
          next_state = ADC_ST_DELAY;
        end
      end
      ADC_ST_DELAY: begin
        if (field) begin
          next_state = ADC_ST_FIELD;
        end else if (count >= delay_target - CNT_W'(1)) begin
          next_state = ADC_ST_IDLE;
        end
      end
      ADC_ST_INIT: begin
        if (count >= delay_target - CNT_W'(1)) begin
          next_state = ADC_ST_IDLE;
        end
      end
      default: next_state = ADC_ST_IDLE;
    endcase
    if (automation[`ADC_AUTO_EN_B:`ADC_AUTO_EN_A] == 2'h0) begin
      next_state = ADC_ST_IDLE;
    end
  end

  assign auto_fire = (state == ADC_ST_DELAY || state == ADC_ST_INIT) && !field
                     && (count >= delay_target - CNT_W'(1))
                     && (automation[`ADC_AUTO_EN_B:`ADC_AUTO_EN_A] != 2'h0);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ADC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // any field sample restarts the no-field window
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (field || next_state != state || state == ADC_ST_IDLE) begin
      count <= '0;
    end else if (count != '1) begin
      count <= count + CNT_W'(1);
    end
  end

  // wake-up from soft power-down
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_trig_d <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      level_trig_d <= level_trig;
      wake_request <= automation[`ADC_FIELD_WAKE] && soft_power_down
                      && level_trig && !level_trig_d;
    end
  end

  // modulation envelope selection
  always_comb begin
    unique case (src)
      ADC_SRC_CODER:    envelope = coder_envelope;
      ADC_SRC_EXTERNAL: envelope = ext_env;
      ADC_SRC_HIGH:     envelope = 1'b1;
      default:          envelope = 1'b0;
    endcase
  end

  // one driver's pin value
  function automatic adc_pin_t drive(input logic en, input logic inv_on, input logic inv_off,
                                     input logic cw, input logic env, input logic car,
                                     input adc_src_t s);
    logic base;
    base = 1'b0;
    if (s == ADC_SRC_HIGH) begin
      base = 1'b1;
    end else if (en) begin
      base = cw ? car : (car & env);
    end
    drive.oe    = (s != ADC_SRC_TRISTATE);
    drive.value = base ^ (en ? inv_on : inv_off);
  endfunction

  assign pin_a = drive(ctrl[`ADC_EN_A], ctrl[`ADC_INV_A_ON], ctrl[`ADC_INV_A_OFF], 1'b0,
                       envelope, carrier, src);
  assign pin_b = drive(ctrl[`ADC_EN_B], ctrl[`ADC_INV_B_ON], ctrl[`ADC_INV_B_OFF],
                       ctrl[`ADC_CW_B], envelope, carrier, src);

  // pins come from flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      antenna_pin_a_o  <= 1'b0;
      antenna_pin_a_oe <= 1'b0;
      antenna_pin_b_o  <= 1'b0;
      antenna_pin_b_oe <= 1'b0;
    end else begin
      antenna_pin_a_o  <= pin_a.value;
      antenna_pin_a_oe <= pin_a.oe;
      antenna_pin_b_o  <= pin_b.value;
      antenna_pin_b_oe <= pin_b.oe;
    end
  end

  // depth setting overridden by full ask
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      full_depth_request <= 1'b0;
    end else begin
      full_depth_request <= automation[`ADC_FULL_ASK];
    end
  end

endmodule // adc_top

// ===== dv/adc_field_model.sv
// Purpose: peer field, carrier and level detector seen by the device
// Assumes: bench commands levels at clock edges
// Notes:   pins move off the edge, being asynchronous to the device
module adc_field_model (
  // commands
  input  wire logic clock,
  input  wire logic field_on,
  input  wire logic carrier_on,
  input  wire logic level_kick,
  // device pins
  output logic      carrier_in,
  output logic      field_detected,
  output logic      rf_level_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  // one driver per pin; levels settle on the first edge, while the device is still in reset
  int hold;
  // trigger held 4 cycles so the synchroniser cannot miss it
  always @(posedge clock) begin
    hold = level_kick ? 4 : (hold > 0 ? hold - 1 : 0);
    field_detected <= #3 field_on;
    carrier_in <= #3 carrier_on;
    rf_level_trigger <= #3 (hold > 0);
  end
endmodule // adc_field_model

// ===== dv/adc_top_properties.sv
// Purpose: port checks of the antenna driver control block
// Assumes: shadows see every host write
// Notes:   pin checks only where auto-on cannot interfere
module adc_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       soft_power_down,
  // outputs
  input wire logic       antenna_pin_a_o,
  input wire logic       antenna_pin_a_oe,
  input wire logic       antenna_pin_b_o,
  input wire logic       antenna_pin_b_oe,
  input wire logic       full_depth_request,
  input wire logic       wake_request,
  input wire logic [1:0] slot_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] auto_sh;
  logic [1:0] src_sh;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      auto_sh <= 8'h00;
      src_sh  <= 2'h1;
    end else if (reg_wr && reg_addr == 8'h15) begin
      auto_sh <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h16) begin
      src_sh <= reg_wdata[5:4];
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  a_check_bit_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h14 |-> !reg_rdata[2])
    else $error("check bit read as one");
  a_rsvd_bit_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h15 |-> !reg_rdata[4])
    else $error("reserved bit read as one");
  a_oe_pair: assert property ($past(arst_n) |-> antenna_pin_a_oe == antenna_pin_b_oe
    && antenna_pin_a_oe == ($past(src_sh) != 2'h0))
    else $error("pin enable wrong");
  a_wake_cause: assert property (wake_request |-> $past(soft_power_down))
    else $error("wake outside power-down");
  a_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake longer than a cycle");
  a_full_ask: assert property (reg_wr && reg_addr == 8'h15 ##1 !reg_wr [*2]
    |-> full_depth_request == $past(reg_wdata[6], 2))
    else $error("full depth request wrong");
  a_slot_idle: assert property (!auto_sh[3] && !$past(auto_sh[3]) |-> slot_n == 2'h0)
    else $error("slot value without avoidance");
  a_off_invert: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata[1:0] == 2'h0 && src_sh == 2'h1
    && auto_sh[1:0] == 2'h0 ##1 !reg_wr [*2] |-> antenna_pin_a_o == $past(reg_wdata[4], 2)
    && antenna_pin_b_o == $past(reg_wdata[5], 2))
    else $error("disabled pin level wrong");
  c_wake: cover property (wake_request);
  c_full: cover property (full_depth_request);
  c_drive: cover property (antenna_pin_a_o && antenna_pin_b_o);
endmodule // adc_checker

bind adc_top adc_checker adc_checker_inst (
  .clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .soft_power_down,
  .antenna_pin_a_o, .antenna_pin_a_oe, .antenna_pin_b_o, .antenna_pin_b_oe,
  .full_depth_request, .wake_request, .slot_n
);

// ===== dv/testbench.sv
// Purpose: self-checking bench of the antenna driver control block
// Assumes: short delay parameters
// Notes:   carrier is a static level so pin values are settled
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ADT = 4;
  localparam int IDT = 8;
  localparam int SLT = 2;
  logic       clock, arst_n, reg_wr, reg_rd, coder_envelope, tx_last_bit_done, soft_power_down;
  logic       external_envelope_input, field_on, carrier_on, level_kick, carrier_in, field_detected;
  logic       rf_level_trigger, pa, pae, pb, pbe, full_depth_request, wake_request;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] slot_n;
  int         n_fail, checks_done, wake_cnt;

  adc_top #(.ADT_CYC(ADT), .IDT_CYC(IDT), .SLOT_CYC(SLT)) adc_top_inst (
    .clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .coder_envelope,
    .tx_last_bit_done, .soft_power_down, .carrier_in, .external_envelope_input, .field_detected,
    .rf_level_trigger, .antenna_pin_a_o(pa), .antenna_pin_a_oe(pae), .antenna_pin_b_o(pb),
    .antenna_pin_b_oe(pbe), .full_depth_request, .wake_request, .slot_n);
  adc_field_model adc_field_model_inst (.clock, .field_on, .carrier_on, .level_kick,
    .carrier_in, .field_detected, .rf_level_trigger);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (wake_request === 1'b1) wake_cnt++;

  task automatic wrap_up();
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("rdata", reg_rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // pin model {b, a}: static high ignores enables, else carrier gated by envelope, or ungated on b with continuous wave
  function automatic logic [1:0] pins(int c, int s, int env, int car);
    int ea, eb, ba, bb;
    ea = c & 1;
    eb = (c >> 1) & 1;
    ba = (s == 3) ? 1 : ea & car & env;
    bb = (s == 3) ? 1 : eb & car & ((c >> 3) | env);
    return {1'(bb ^ (c >> (eb ? 7 : 5))), 1'(ba ^ (c >> (ea ? 6 : 4)))};
  endfunction

  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end

  initial begin
    int c, s, env;
    c = $urandom(32'h99d3);
    {arst_n, reg_wr, reg_rd, coder_envelope, tx_last_bit_done, soft_power_down} = 6'h00;
    {external_envelope_input, field_on, carrier_on, level_kick} = 4'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    {n_fail, checks_done, wake_cnt} = 0;
    idle(6);
    arst_n <= 1'b1;
    rd(8'h14, 8'h80);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h10);
    rd(8'h3C, 8'h00);
    repeat (12) begin
      c = $urandom & 8'hFB;
      s = $urandom % 4;
      @(posedge clock);
      coder_envelope <= 1'($urandom);
      external_envelope_input <= 1'($urandom);
      carrier_on <= 1'($urandom);
      wr(8'h16, 8'(s << 4));
      wr(8'h14, 8'(c));
      idle(6);
      @(negedge clock);
      env = (s == 1) ? coder_envelope : external_envelope_input;
      chk("oe", {6'h00, pbe, pae}, {6'h00, {2{s != 0}}});
      if (s != 0) chk("pins", {6'h00, pb, pa}, {6'h00, pins(c, s, env, carrier_on)});
      rd(8'h14, 8'(c));
    end
    repeat (4) begin
      c = $urandom & 8'hE8;
      wr(8'h15, 8'(c));
      rd(8'h15, 8'(c & 8'hE8));
      chk("full", {7'h00, full_depth_request}, {7'h00, 1'(c >> 6)});
    end
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h00);
    @(posedge clock);
    field_on <= 1'b1;
    idle(6);
    wr(8'h14, 8'h07);
    rd(8'h14, 8'h00);
    wr(8'h14, 8'h03);
    rd(8'h14, 8'h03);
    @(posedge clock);
    field_on <= 1'b0;
    idle(6);
    wr(8'h14, 8'h04);
    wr(8'h14, 8'h07);
    rd(8'h14, 8'h03);
    wr(8'h15, 8'h80);
    @(posedge clock);
    tx_last_bit_done <= 1'b1;
    @(posedge clock);
    tx_last_bit_done <= 1'b0;
    rd(8'h14, 8'h00);
    wr(8'h15, 8'h0B);
    @(posedge clock);
    field_on <= 1'b1;
    idle(6);
    field_on <= 1'b0;
    idle(ADT + SLT * 3 + 10);
    rd(8'h14, 8'h03);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h07);
    idle(IDT + SLT * 3 + 10);
    rd(8'h15, 8'h03);
    rd(8'h14, 8'h03);
    wr(8'h15, 8'h20);
    @(posedge clock);
    soft_power_down <= 1'b1;
    level_kick <= 1'b1;
    @(posedge clock);
    level_kick <= 1'b0;
    idle(12);
    soft_power_down <= 1'b0;
    level_kick <= 1'b1;
    @(posedge clock);
    level_kick <= 1'b0;
    idle(12);
    chk("wakes", 8'(wake_cnt), 8'h01);
    wrap_up();
  end
endmodule // testbench

// ===== inc/adc_defines.svh
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// register offsets
`define ADC_OFS_CTRL      8'h14
`define ADC_OFS_AUTO      8'h15
`define ADC_OFS_SRC       8'h16

// reset values
`define ADC_RST_CTRL      8'h80
`define ADC_RST_AUTO      8'h00
`define ADC_RST_SRC       8'h10

// driver control fields
`define ADC_INV_B_ON      7
`define ADC_INV_A_ON      6
`define ADC_INV_B_OFF     5
`define ADC_INV_A_OFF     4
`define ADC_CW_B          3
`define ADC_FIELD_CHECK   2
`define ADC_EN_B          1
`define ADC_EN_A          0

// automation fields
`define ADC_AUTO_OFF      7
`define ADC_FULL_ASK      6
`define ADC_FIELD_WAKE    5
`define ADC_AUTO_RSVD     4
`define ADC_CA_ON         3
`define ADC_INIT_AVOID    2
`define ADC_AUTO_EN_B     1
`define ADC_AUTO_EN_A     0

// source select field
`define ADC_SRC_LSB       4
`define ADC_SRC_MSB       5

// delay times in ns and clock period
`define ADC_CLK_PERIOD_NS 10
`define ADC_ADT_NS        20000
`define ADC_IDT_NS        40000
`define ADC_SLOT_NS       5000
`define ADC_ADT_CYC       ((`ADC_ADT_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_IDT_CYC       ((`ADC_IDT_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_SLOT_CYC      ((`ADC_SLOT_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`endif

// ===== inc/adc_pkg.sv
// Purpose: types of the antenna driver control block
// Assumes: constants live in adc_defines.svh
// Notes:   none
package adc_pkg;

  typedef enum logic [1:0] {
    ADC_SRC_TRISTATE = 2'h0,
    ADC_SRC_CODER    = 2'h1,
    ADC_SRC_EXTERNAL = 2'h2,
    ADC_SRC_HIGH     = 2'h3
  } adc_src_t;

  typedef enum logic [3:0] {
    ADC_ST_IDLE  = 4'h1,
    ADC_ST_FIELD = 4'h2,
    ADC_ST_DELAY = 4'h4,
    ADC_ST_INIT  = 4'h8
  } adc_state_t;

  // one antenna pin as output value plus enable
  typedef struct packed {
    logic value;
    logic oe;
  } adc_pin_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adc_bus_t;

endpackage
